// ### core/bbm_bus_region_bitband_map.v
`timescale 1ns/1ps
`include "bbm_map_defs.vh"

// Operation
// - code region: normal, executable
// - sram region: normal, executable
// - peripheral region: device, execute-never
// - external ram: normal, executable
// - external device: device, execute-never
// - private bus: strongly ordered, execute-never; above reserved
// - early and speculative fetches accepted
// - protection unit overrides type and execute-never
// - data barrier completes outstanding transactions first
// - sync barrier completes outstanding transactions first
// - instruction barrier flushes prefetched instructions
// - strongly ordered accesses stay in order
// - lowest 1 MB of peripheral and 32 KB of sram bit-banded, 32 MB and 1 MB alias, word per bit
// - alias access keeps original size
// - sram alias remaps data, fetches pass
// - peripheral alias remaps data, fetches rejected
// - alias write is read, bit change, write back
// - offset is byte times 32 plus bit times 4
// - alias write uses only data bit 0
// - alias read returns 0 or 1
// - direct bit-band accesses not remapped
// - execute-never fault only on execution
// - device writes posted except bit-band alias writes, strongly ordered not
module bbm_bus_region_bitband_map
(
    input  wire        i_clock,
    input  wire        i_srst,
    input  wire        i_req,
    input  wire [1:0]  i_barrier,
    input  wire        i_fetch,
    input  wire        i_write,
    input  wire [1:0]  i_size,
    input  wire [31:0] i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_pu_enable,
    input  wire        i_pu_hit,
    input  wire [1:0]  i_pu_type,
    input  wire        i_pu_xn,
    input  wire        i_exec_valid,
    input  wire        i_exec_xn,
    input  wire        i_mack,
    input  wire [31:0] i_mrdata,
    output reg         o_ready,
    output reg         o_done,
    output reg         o_error,
    output reg  [31:0] o_rdata,
    output reg         o_fetch_xn,
    output reg  [2:0]  o_region,
    output reg  [1:0]  o_mem_type,
    output reg         o_execute_never,
    output reg         o_flush_prefetch,
    output reg         o_sync_done,
    output reg         o_xn_fault,
    output reg         o_mreq,
    output reg         o_mwrite,
    output reg  [1:0]  o_msize,
    output reg  [31:0] o_maddr,
    output reg  [31:0] o_mwdata,
    output reg         o_mlock
);

    // ======================================================================
    // states
    // ======================================================================
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_ACCESS = 3'h1;
    localparam [2:0] ST_POST   = 3'h2;
    localparam [2:0] ST_RMW_RD = 3'h3;
    localparam [2:0] ST_RMW_WR = 3'h4;
    localparam [2:0] ST_BAR    = 3'h5;
    localparam [2:0] ST_RESP   = 3'h6;

    reg  [2:0]  state;
    reg  [1:0]  bar_kind;
    reg         alias_write;
    reg         alias_bit;
    reg  [4:0]  bit_pos;
    reg         resp_err;
    reg         resp_xn;

    wire [2:0]  dec_region;
    wire [1:0]  dec_type;
    wire        dec_xn;
    wire        dec_alias;
    wire        dec_reject;
    wire [31:0] dec_addr;
    wire [4:0]  dec_bit_pos;
    wire        take;
    wire [31:0] bit_mask;
    wire [31:0] merged_word;

    // ======================================================================
    // address decode
    // ======================================================================
    bbm_region_decode u_decode
    (
        .i_addr          (i_addr),
        .i_size          (i_size),
        .i_fetch         (i_fetch),
        .i_pu_enable     (i_pu_enable),
        .i_pu_hit        (i_pu_hit),
        .i_pu_type       (i_pu_type),
        .i_pu_xn         (i_pu_xn),
        .o_region        (dec_region),
        .o_mem_type      (dec_type),
        .o_execute_never (dec_xn),
        .o_alias         (dec_alias),
        .o_fetch_reject  (dec_reject),
        .o_phys_addr     (dec_addr),
        .o_bit_pos       (dec_bit_pos)
    );

    assign take        = i_req && o_ready;
    assign bit_mask    = 32'h0000_0001 << bit_pos;
    // only target bit changes
    assign merged_word = alias_bit ? (i_mrdata | bit_mask) : (i_mrdata & ~bit_mask);

    // ======================================================================
    // sequencer
    // ======================================================================
    always @(posedge i_clock)
    begin
        if (i_srst)
        begin
            state            <= ST_IDLE;
            bar_kind         <= `BBM_BAR_NONE;
            alias_write      <= 1'b0;
            alias_bit        <= 1'b0;
            bit_pos          <= 5'h00;
            resp_err         <= 1'b0;
            resp_xn          <= 1'b0;
            o_ready          <= 1'b1;
            o_done           <= 1'b0;
            o_error          <= 1'b0;
            o_rdata          <= 32'h0000_0000;
            o_fetch_xn       <= 1'b0;
            o_region         <= `BBM_RGN_CODE;
            o_mem_type       <= `BBM_TYPE_NORMAL;
            o_execute_never  <= 1'b0;
            o_flush_prefetch <= 1'b0;
            o_sync_done      <= 1'b0;
            o_xn_fault       <= 1'b0;
            o_mreq           <= 1'b0;
            o_mwrite         <= 1'b0;
            o_msize          <= `BBM_SIZE_WORD;
            o_maddr          <= 32'h0000_0000;
            o_mwdata         <= 32'h0000_0000;
            o_mlock          <= 1'b0;
        end
        else
        begin
            o_done           <= 1'b0;
            o_error          <= 1'b0;
            o_fetch_xn       <= 1'b0;
            o_flush_prefetch <= 1'b0;
            o_sync_done      <= 1'b0;
            // fault on execution
            o_xn_fault       <= i_exec_valid && i_exec_xn;
            case (state)
                ST_IDLE:
                begin
                    if (take && i_barrier != `BBM_BAR_NONE)
                    begin
                        // idle means nothing is outstanding
                        bar_kind <= i_barrier;
                        o_ready  <= 1'b0;
                        state    <= ST_BAR;
                    end
                    else if (take)
                    begin
                        o_ready         <= 1'b0;
                        o_region        <= dec_region;
                        o_mem_type      <= dec_type;
                        o_execute_never <= dec_xn;
                        o_rdata         <= 32'h0000_0000;
                        alias_write     <= i_write;
                        alias_bit       <= i_wdata[0];
                        bit_pos         <= dec_bit_pos;
                        resp_err        <= 1'b0;
                        resp_xn         <= 1'b0;
                        if (dec_reject || dec_region == `BBM_RGN_RSVD)
                        begin
                            resp_err <= 1'b1;
                            state    <= ST_RESP;
                        end
                        else if (i_fetch && dec_xn)
                        begin
                            // prefetch only tagged, no bus access
                            resp_xn <= 1'b1;
                            state   <= ST_RESP;
                        end
                        else
                        begin
                            o_mreq  <= 1'b1;
                            o_maddr <= dec_addr;
                            o_msize <= i_size;
                            if (dec_alias)
                            begin
                                o_mwrite <= 1'b0;
                                o_mlock  <= i_write;
                                state    <= ST_RMW_RD;
                            end
                            else if (i_write && dec_type == `BBM_TYPE_DEVICE)
                            begin
                                o_mwrite <= 1'b1;
                                o_mwdata <= i_wdata;
                                o_done   <= 1'b1;
                                state    <= ST_POST;
                            end
                            else
                            begin
                                // wait for completion
                                o_mwrite <= i_write;
                                o_mwdata <= i_wdata;
                                state    <= ST_ACCESS;
                            end
                        end
                    end
                end
                ST_ACCESS:
                begin
                    if (i_mack)
                    begin
                        o_mreq  <= 1'b0;
                        o_rdata <= o_mwrite ? 32'h0000_0000 : i_mrdata;
                        o_done  <= 1'b1;
                        o_ready <= 1'b1;
                        state   <= ST_IDLE;
                    end
                end
                ST_POST:
                begin
                    // posted write still blocks later accesses
                    if (i_mack)
                    begin
                        o_mreq  <= 1'b0;
                        o_ready <= 1'b1;
                        state   <= ST_IDLE;
                    end
                end
                ST_RMW_RD:
                begin
                    if (i_mack && alias_write)
                    begin
                        o_mwrite <= 1'b1;
                        o_mwdata <= merged_word;
                        state    <= ST_RMW_WR;
                    end
                    else if (i_mack)
                    begin
                        o_mreq  <= 1'b0;
                        o_rdata <= {31'h0000_0000, i_mrdata[bit_pos]};
                        o_done  <= 1'b1;
                        o_ready <= 1'b1;
                        state   <= ST_IDLE;
                    end
                end
                ST_RMW_WR:
                begin
                    if (i_mack)
                    begin
                        o_mreq   <= 1'b0;
                        o_mwrite <= 1'b0;
                        o_mlock  <= 1'b0;
                        o_done   <= 1'b1;
                        o_ready  <= 1'b1;
                        state    <= ST_IDLE;
                    end
                end
                ST_BAR:
                begin
                    o_done           <= 1'b1;
                    o_sync_done      <= (bar_kind == `BBM_BAR_DSB);
                    o_flush_prefetch <= (bar_kind == `BBM_BAR_ISB);
                    o_ready          <= 1'b1;
                    state            <= ST_IDLE;
                end
                ST_RESP:
                begin
                    o_done     <= 1'b1;
                    o_error    <= resp_err;
                    o_fetch_xn <= resp_xn;
                    o_ready    <= 1'b1;
                    state      <= ST_IDLE;
                end
                default:
                begin
                    o_mreq  <= 1'b0;
                    o_mlock <= 1'b0;
                    o_ready <= 1'b1;
                    state   <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ### core/bbm_region_decode.v
`timescale 1ns/1ps
`include "bbm_map_defs.vh"

module bbm_region_decode
(
    input  wire [31:0] i_addr,
    input  wire [1:0]  i_size,
    input  wire        i_fetch,
    input  wire        i_pu_enable,
    input  wire        i_pu_hit,
    input  wire [1:0]  i_pu_type,
    input  wire        i_pu_xn,
    output reg  [2:0]  o_region,
    output reg  [1:0]  o_mem_type,
    output reg         o_execute_never,
    output reg         o_alias,
    output reg         o_fetch_reject,
    output reg  [31:0] o_phys_addr,
    output reg  [4:0]  o_bit_pos
);

    reg         sram_alias;
    reg         per_alias;
    reg  [24:0] alias_ofs;
    reg  [31:0] byte_addr;

    // ======================================================================
    // fixed map, then protection override
    // ======================================================================
    always @*
    begin
        o_region        = `BBM_RGN_RSVD;
        o_mem_type      = `BBM_TYPE_STRONG;
        o_execute_never = 1'b1;
        if (i_addr <= `BBM_CODE_END)
        begin
            o_region        = `BBM_RGN_CODE;
            o_mem_type      = `BBM_TYPE_NORMAL;
            o_execute_never = 1'b0;
        end
        else if (i_addr >= `BBM_SRAM_BASE && i_addr <= `BBM_SRAM_END)
        begin
            o_region        = `BBM_RGN_SRAM;
            o_mem_type      = `BBM_TYPE_NORMAL;
            o_execute_never = 1'b0;
        end
        else if (i_addr >= `BBM_PERIPH_BASE && i_addr <= `BBM_PERIPH_END)
        begin
            o_region        = `BBM_RGN_PERIPH;
            o_mem_type      = `BBM_TYPE_DEVICE;
            o_execute_never = 1'b1;
        end
        else if (i_addr >= `BBM_EXT_RAM_BASE && i_addr <= `BBM_EXT_RAM_END)
        begin
            o_region        = `BBM_RGN_EXT_RAM;
            o_mem_type      = `BBM_TYPE_NORMAL;
            o_execute_never = 1'b0;
        end
        else if (i_addr >= `BBM_EXT_DEV_BASE && i_addr <= `BBM_EXT_DEV_END)
        begin
            o_region        = `BBM_RGN_EXT_DEV;
            o_mem_type      = `BBM_TYPE_DEVICE;
            o_execute_never = 1'b1;
        end
        else if (i_addr >= `BBM_PPB_BASE && i_addr <= `BBM_PPB_END)
        begin
            o_region        = `BBM_RGN_PPB;
            o_mem_type      = `BBM_TYPE_STRONG;
            o_execute_never = 1'b1;
        end
        if (i_pu_enable && i_pu_hit && o_region != `BBM_RGN_RSVD)
        begin
            o_mem_type      = i_pu_type;
            o_execute_never = i_pu_xn;
        end
    end

    // ======================================================================
    // alias remap
    // ======================================================================
    always @*
    begin
        sram_alias = (i_addr >= `BBM_SRAM_ALIAS_BASE) && (i_addr <= `BBM_SRAM_ALIAS_END);
        per_alias  = (i_addr >= `BBM_PER_ALIAS_BASE) && (i_addr <= `BBM_PER_ALIAS_END);
        alias_ofs  = i_addr[24:0];
        o_alias        = (sram_alias || per_alias) && !i_fetch;
        o_fetch_reject = per_alias && i_fetch;
        byte_addr = (per_alias ? `BBM_PER_BB_BASE : `BBM_SRAM_BB_BASE)
                  | {12'h000, alias_ofs[24:5]};
        o_bit_pos = {byte_addr[1:0], alias_ofs[4:2]};
        o_phys_addr = i_addr;
        if (o_alias)
        begin
            case (i_size)
                `BBM_SIZE_BYTE: o_phys_addr = byte_addr;
                `BBM_SIZE_HALF: o_phys_addr = {byte_addr[31:1], 1'b0};
                default:        o_phys_addr = {byte_addr[31:2], 2'b00};
            endcase
        end
    end

endmodule

// ### include/bbm_map_defs.vh
`ifndef BBM_MAP_DEFS_VH
`define BBM_MAP_DEFS_VH

// ==========================================================================
// region bounds
// ==========================================================================
`define BBM_CODE_BASE        32'h0000_0000
`define BBM_CODE_END         32'h1FFF_FFFF
`define BBM_SRAM_BASE        32'h2000_0000
`define BBM_SRAM_END         32'h3FFF_FFFF
`define BBM_PERIPH_BASE      32'h4000_0000
`define BBM_PERIPH_END       32'h5FFF_FFFF
`define BBM_EXT_RAM_BASE     32'h6000_0000
`define BBM_EXT_RAM_END      32'h9FFF_FFFF
`define BBM_EXT_DEV_BASE     32'hA000_0000
`define BBM_EXT_DEV_END      32'hDFFF_FFFF
`define BBM_PPB_BASE         32'hE000_0000
`define BBM_PPB_END          32'hE00F_FFFF
`define BBM_RSVD_BASE        32'hE010_0000

// ==========================================================================
// bit-band windows
// ==========================================================================
`define BBM_SRAM_BB_BASE     32'h2000_0000
`define BBM_SRAM_BB_END      32'h2000_7FFF
`define BBM_SRAM_ALIAS_BASE  32'h2200_0000
`define BBM_SRAM_ALIAS_END   32'h220F_FFFF
`define BBM_PER_BB_BASE      32'h4000_0000
`define BBM_PER_BB_END       32'h400F_FFFF
`define BBM_PER_ALIAS_BASE   32'h4200_0000
`define BBM_PER_ALIAS_END    32'h43FF_FFFF

// ==========================================================================
// region codes
// ==========================================================================
`define BBM_RGN_CODE         3'h0
`define BBM_RGN_SRAM         3'h1
`define BBM_RGN_PERIPH       3'h2
`define BBM_RGN_EXT_RAM      3'h3
`define BBM_RGN_EXT_DEV      3'h4
`define BBM_RGN_PPB          3'h5
`define BBM_RGN_RSVD         3'h6

// ==========================================================================
// memory types
// ==========================================================================
`define BBM_TYPE_NORMAL      2'h0
`define BBM_TYPE_DEVICE      2'h1
`define BBM_TYPE_STRONG      2'h2

// ==========================================================================
// access sizes and barrier kinds
// ==========================================================================
`define BBM_SIZE_BYTE        2'h0
`define BBM_SIZE_HALF        2'h1
`define BBM_SIZE_WORD        2'h2
`define BBM_BAR_NONE         2'h0
`define BBM_BAR_DMB          2'h1
`define BBM_BAR_DSB          2'h2
`define BBM_BAR_ISB          2'h3

`endif

// ### verification/bbm_bus_region_bitband_map_bench.sv
`timescale 1ns/1ps
`include "bbm_map_defs.vh"

module bbm_bus_region_bitband_map_bench;
    typedef struct packed {logic [31:0] a; logic f; logic [2:0] rg;
        logic [1:0] ty; logic xn; logic er; logic fx;} bbm_row_t;

    logic        i_clock = 0;
    logic        i_srst = 1;
    logic        i_req = 0;
    logic [1:0]  i_barrier = 0;
    logic        i_fetch = 0;
    logic        i_write = 0;
    logic [1:0]  i_size = 2;
    logic [31:0] i_addr = 0;
    logic [31:0] i_wdata = 0;
    logic        i_pu_enable = 0;
    logic        i_pu_hit = 0;
    logic [1:0]  i_pu_type = 0;
    logic        i_pu_xn = 0;
    logic        i_exec_valid = 0;
    logic        i_exec_xn = 0;
    logic [3:0]  slow = 0;
    wire         i_mack;
    wire  [31:0] i_mrdata;
    wire         o_ready, o_done, o_error, o_fetch_xn, o_execute_never, o_flush_prefetch;
    wire         o_sync_done, o_xn_fault, o_mreq, o_mwrite, o_mlock;
    wire  [2:0]  o_region;
    wire  [1:0]  o_mem_type, o_msize;
    wire  [31:0] o_rdata, o_maddr, o_mwdata;
    int          miscompares = 0;
    int          cmp_count = 0;
    logic [31:0] ma, rd;
    logic [1:0]  ms;
    logic        er, fx, sy, fl, pm, got;

    bbm_row_t rows [14] = '{
        '{32'h0000_0100, 1, 0, 0, 0, 0, 0}, '{32'h1FFF_FFFC, 0, 0, 0, 0, 0, 0},
        '{32'h2000_0040, 1, 1, 0, 0, 0, 0}, '{32'h3FFF_FFFC, 0, 1, 0, 0, 0, 0},
        '{32'h4000_0100, 0, 2, 1, 1, 0, 0}, '{32'h5FFF_FFFC, 1, 2, 1, 1, 0, 1},
        '{32'h6000_0000, 1, 3, 0, 0, 0, 0}, '{32'h9FFF_FFFC, 0, 3, 0, 0, 0, 0},
        '{32'hA000_0000, 0, 4, 1, 1, 0, 0}, '{32'hDFFF_FFFC, 1, 4, 1, 1, 0, 1},
        '{32'hE000_E000, 0, 5, 2, 1, 0, 0}, '{32'hE00F_FFFC, 0, 5, 2, 1, 0, 0},
        '{32'hE010_0000, 0, 6, 2, 1, 1, 0}, '{32'h4200_0000, 1, 2, 1, 1, 1, 0}};

    bbm_bus_region_bitband_map u_dut (.*);

    bbm_core_mem_model u_mem
    (
        .i_clock  (i_clock),
        .i_mreq   (o_mreq),
        .i_mwrite (o_mwrite),
        .i_msize  (o_msize),
        .i_maddr  (o_maddr),
        .i_mwdata (o_mwdata),
        .i_wait   (slow),
        .o_mack   (i_mack),
        .o_mrdata (i_mrdata)
    );

    initial
    begin
        forever #12.5 i_clock = ~i_clock;
    end

    // ======================================================================
    // helpers
    // ======================================================================
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_until_ready();
        repeat (40)
        begin
            if (o_ready === 1'b1)
                return;
            @(posedge i_clock);
            #1;
        end
        miscompares++;
        results();
    endtask

    task automatic acc(input [31:0] a, input [1:0] b, input f, input w, input [1:0] s,
                       input [31:0] d);
        wait_until_ready();
        {i_req, i_barrier, i_fetch, i_write, i_size, i_addr, i_wdata} = {1'b1, b, f, w, s, a, d};
        @(posedge i_clock);
        #1;
        i_req = 0;
        got = 0;
        repeat (40)
        begin
            if (o_mreq === 1'b1 && !got)
                {ma, ms, got} = {o_maddr, o_msize, 1'b1};
            if (o_done === 1'b1)
                break;
            @(posedge i_clock);
            #1;
        end
        if (o_done !== 1'b1)
        begin
            miscompares++;
            results();
        end
        {rd, er, fx, sy, fl, pm} = {o_rdata, o_error, o_fetch_xn, o_sync_done, o_flush_prefetch, o_mreq};
    endtask

    // ======================================================================
    // sequence
    // ======================================================================
    initial
    begin
        repeat (6) @(posedge i_clock);
        #1;
        i_srst = 0;
        foreach (rows[i])
        begin
            acc(rows[i].a, `BBM_BAR_NONE, rows[i].f, 1'b0, `BBM_SIZE_WORD, 32'h0000_0000);
            chk("region", rows[i].rg, o_region);
            chk("type", rows[i].ty, o_mem_type);
            chk("xn", rows[i].xn, o_execute_never);
            chk("error", rows[i].er, er);
            chk("fetch_xn", rows[i].fx, fx);
        end
        $display("test region map done");
        slow = 2;
        acc(32'h2000_0000, 0, 0, 1, `BBM_SIZE_WORD, 32'h0000_0001);
        acc(32'h2200_001C, 0, 0, 1, `BBM_SIZE_WORD, 32'h0000_00FF);
        acc(32'h2200_0000, 0, 0, 1, `BBM_SIZE_WORD, 32'h0000_000E);
        acc(32'h2000_0000, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("sram word", 32'h0000_0080, rd);
        acc(32'h2200_001C, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("alias set", 32'h0000_0001, rd);
        acc(32'h2200_0000, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("alias clear", 32'h0000_0000, rd);
        acc(32'h4200_0068, 0, 0, 1, `BBM_SIZE_HALF, 32'hFFFF_FFFF);
        chk("alias size", `BBM_SIZE_HALF, ms);
        acc(32'h4000_0000, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("periph word", 32'h0400_0000, rd);
        acc(32'h43FF_FFFC, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("alias top", 32'h400F_FFFC, ma);
        acc(32'h2200_0000, 0, 1, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("alias fetch", 32'h2200_0000, ma);
        $display("test bit band done");
        {i_pu_enable, i_pu_hit, i_pu_type, i_pu_xn} = {2'b11, `BBM_TYPE_DEVICE, 1'b1};
        acc(32'h0000_0200, 0, 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
        chk("pu type", `BBM_TYPE_DEVICE, o_mem_type);
        chk("pu xn", 1, o_execute_never);
        i_pu_enable = 0;
        slow = 4;
        acc(32'hA000_0010, 0, 0, 1, `BBM_SIZE_WORD, 32'h1234_5678);
        chk("posted", 1, pm);
        acc(32'hE000_E010, 0, 0, 1, `BBM_SIZE_WORD, 32'h0000_0001);
        chk("so wait", 0, pm);
        for (int b = 1; b < 4; b++)
        begin
            acc(32'h0000_0000, b[1:0], 0, 0, `BBM_SIZE_WORD, 32'h0000_0000);
            chk("sync", b == 2, sy);
            chk("flush", b == 3, fl);
        end
        $display("test attributes done");
        {i_exec_valid, i_exec_xn} = 2'b11;
        @(posedge i_clock);
        #1;
        {i_exec_valid, i_exec_xn} = 2'b10;
        chk("xn fault", 1, o_xn_fault);
        @(posedge i_clock);
        #1;
        i_exec_valid = 0;
        chk("no fault", 0, o_xn_fault);
        {i_req, i_barrier, i_write, i_addr} = {4'b1010, 32'h6000_0000};
        @(posedge i_clock);
        #1;
        i_req = 0;
        @(posedge i_clock);
        #1;
        i_srst = 1;
        repeat (2) @(posedge i_clock);
        #1;
        i_srst = 0;
        chk("reset ready", 1, o_ready);
        chk("reset mreq", 0, o_mreq);
        chk("reset lock", 0, o_mlock);
        $display("test fault and reset done");
        results();
    end
endmodule

// ### verification/bbm_core_mem_model.sv
`timescale 1ns/1ps
`include "bbm_map_defs.vh"

module bbm_core_mem_model
(
    input  wire        i_clock,
    input  wire        i_mreq,
    input  wire        i_mwrite,
    input  wire [1:0]  i_msize,
    input  wire [31:0] i_maddr,
    input  wire [31:0] i_mwdata,
    input  wire [3:0]  i_wait,
    output logic       o_mack = 0,
    output logic [31:0] o_mrdata = 0
);
    logic [31:0] mem [logic [29:0]];
    logic [31:0] cur;
    logic [3:0]  be;
    logic [3:0]  cnt = 0;

    // byte-lane memory, ack after i_wait cycles
    always @(posedge i_clock)
    begin
        if (i_mreq && !o_mack && cnt >= i_wait)
        begin
            cur = mem.exists(i_maddr[31:2]) ? mem[i_maddr[31:2]] : 32'h0000_0000;
            be = (i_msize == `BBM_SIZE_WORD) ? 4'hF :
                 (i_msize == `BBM_SIZE_HALF) ? (4'h3 << {i_maddr[1], 1'b0}) :
                 (4'h1 << i_maddr[1:0]);
            if (i_mwrite)
            begin
                for (int k = 0; k < 32; k++)
                    if (be[k / 8])
                        cur[k] = i_mwdata[k];
                mem[i_maddr[31:2]] = cur;
            end
            o_mack <= 1'b1;
            o_mrdata <= cur;
            cnt <= 0;
        end
        else
        begin
            // no stale data between acks
            o_mack <= 1'b0;
            o_mrdata <= ~o_mrdata;
            cnt <= (i_mreq && !o_mack) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ### verification/bbm_map_checker_sva.sv
`timescale 1ns/1ps
`include "bbm_map_defs.vh"

module bbm_map_checker
(
    input  wire        i_clock,
    input  wire        i_srst,
    input  wire        i_req,
    input  wire [1:0]  i_barrier,
    input  wire [31:0] i_addr,
    input  wire        i_exec_valid,
    input  wire        i_exec_xn,
    input  wire        i_mack,
    input  wire        o_ready,
    input  wire        o_done,
    input  wire        o_error,
    input  wire        o_fetch_xn,
    input  wire [1:0]  o_mem_type,
    input  wire        o_flush_prefetch,
    input  wire        o_sync_done,
    input  wire        o_xn_fault,
    input  wire        o_mreq,
    input  wire        o_mwrite,
    input  wire [31:0] o_maddr,
    input  wire        o_mlock
);
    wire take;
    assign take = i_req && o_ready;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // ======================================================================
    // assertions
    // ======================================================================
    a_error_done: assert property (o_error |-> o_done)
        else $error("error alone");
    a_fetch_nobus: assert property (o_fetch_xn |-> o_done && !o_mreq)
        else $error("fetch on bus");
    a_dmb_order: assert property (take && i_barrier == `BBM_BAR_DMB |=>
        !o_ready ##1 o_done && !o_mreq)
        else $error("bad dmb");
    a_dsb_done: assert property (take && i_barrier == `BBM_BAR_DSB |->
        ##2 o_sync_done && !o_flush_prefetch)
        else $error("bad dsb");
    a_isb_flush: assert property (take && i_barrier == `BBM_BAR_ISB |->
        ##2 o_flush_prefetch && !o_sync_done)
        else $error("bad isb");
    a_rsvd_error: assert property (take && i_barrier == `BBM_BAR_NONE &&
        i_addr >= `BBM_RSVD_BASE |-> ##2 o_error)
        else $error("no reserved error");
    a_req_stable: assert property (o_mreq && !i_mack |=>
        o_mreq && $stable(o_maddr) && $stable(o_mwrite))
        else $error("request unstable");
    a_rmw_read: assert property ($rose(o_mlock) |-> o_mreq && !o_mwrite)
        else $error("lock not read");
    a_rmw_unlock: assert property (o_mlock && o_mwrite && i_mack |=>
        !o_mlock && o_done)
        else $error("lock stuck");
    a_so_no_post: assert property (o_mreq && o_mwrite &&
        o_mem_type == `BBM_TYPE_STRONG |-> !o_done)
        else $error("so write posted");
    a_fault_exec: assert property (i_exec_valid && i_exec_xn |=> o_xn_fault)
        else $error("no fault");
    a_fault_cause: assert property (o_xn_fault |-> $past(i_exec_valid) && $past(i_exec_xn))
        else $error("stray fault");

    c_rmw: cover property ($rose(o_mlock));
    c_isb: cover property (o_flush_prefetch);
    c_fault: cover property (o_xn_fault);
endmodule

bind bbm_bus_region_bitband_map bbm_map_checker u_chk (.*);
